// ===== inc/dsc_consts.svh
// dsc_consts.svh: register offsets, field positions and reset values of the
// dual-channel input steering block.
// assumes inclusion by bare name from inc/; definitions only.
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH

// ==========================================================
// widths
`define DSC_WORD_W        16
`define DSC_ADDR_W        8

// ==========================================================
// register byte offsets
`define DSC_CTRL_OFS      8'h00
`define DSC_STAT_OFS      8'h04
`define DSC_CNT_OFS       8'h08

// ==========================================================
// control field positions
`define DSC_C_ILV         0
`define DSC_C_BFLAG       1
`define DSC_C_BITREV      2
`define DSC_C_PLL         3
`define DSC_C_LOCKCLK     4
`define DSC_C_SYNC_LO     5
`define DSC_C_SYNC_HI     8
`define DSC_CTRL_RST      32'h000001e0

// ==========================================================
// status field positions
`define DSC_S_GATE        0
`define DSC_S_LOCK        1
`define DSC_S_PDN         2
`define DSC_S_NEXTB       3
`define DSC_S_LOCKOUT     4

`endif

// ===== inc/dsc_pkg.sv
// dsc_pkg: types shared by the steering block.
// assumes dsc_consts.svh is on the include path.
`include "dsc_consts.svh"

package dsc_pkg;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic                   ilv;
    logic                   bflag_sel;
    logic                   bit_rev;
    logic                   pll_mode;
    logic                   lock_clk;
    logic [3:0]             sync_mask;
  } dsc_cfg_t;

  typedef struct packed {
    logic                   valid;
    logic [`DSC_WORD_W-1:0] code_true;
    logic [`DSC_WORD_W-1:0] code_comp;
  } dsc_chan_t;

  typedef struct packed {
    logic                   nco;
    logic                   mixer;
    logic                   div;
    logic                   fifo;
  } dsc_init_t;

  typedef enum logic [0:0] {
    DSC_PH_A = 1'b0,
    DSC_PH_B = 1'b1
  } dsc_phase_t;

endpackage : dsc_pkg

// ===== core/dsc_sync.sv
// dsc_sync: two-flop synchroniser for a vector of unrelated pin levels.
// assumes each bit is a slow level or a word held steady across two clocks.
`timescale 1ns/1ps
`default_nettype none

module dsc_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_d,
  output var  logic [W-1:0] o_q
);

  logic [W-1:0] meta_r;

  // ==========================================================
  // first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_r <= '0;
      o_q    <= '0;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end

endmodule : dsc_sync
`default_nettype wire

// ===== core/dsc_steer.sv
// dsc_steer: input-side control of a dual-channel interpolating converter.
// assumes pins arrive asynchronously, one sample word per i_clk, apb on i_clk.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module dsc_steer
  import dsc_pkg::*;
#(
  parameter int DIV_W = 2
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_sys_rst,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [`DSC_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output var  logic [31:0]            o_prdata,
  output var  logic                   o_pready,
  output var  logic                   o_pslverr,
  input  wire logic                   i_tx_gate,
  input  wire logic [`DSC_WORD_W-1:0] i_chan_a_word,
  input  wire logic [`DSC_WORD_W-1:0] i_chan_b_word,
  input  wire logic                   i_b_sample_flag,
  input  wire logic                   i_phase_sync_in,
  input  wire logic                   i_chip_reset_n,
  input  wire logic                   i_sleep,
  input  wire logic                   i_pll_locked,
  output var  dsc_chan_t              o_chan_a,
  output var  dsc_chan_t              o_chan_b,
  output var  dsc_init_t              o_init,
  output var  logic                   o_power_down,
  output var  logic                   o_loop_lock_out
);

  localparam int WW = `DSC_WORD_W;
  localparam int SW = 2 * WW + 6;

  // ==========================================================
  // pin synchronisers
  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_s;
  logic [WW-1:0] s_a_word;
  logic [WW-1:0] s_b_word;
  logic          s_flag;
  logic          s_gate;
  logic          s_sync;
  logic          s_rst_n;
  logic          s_sleep;
  logic          s_lock;

  assign pins_raw = {i_chan_a_word, i_chan_b_word, i_b_sample_flag, i_tx_gate,
                     i_phase_sync_in, i_chip_reset_n, i_sleep, i_pll_locked};

  // limitation: the word buses pass the same two flops as the levels, so the
  // source must launch them from a clock related to i_clk; a free-running
  // foreign clock would need the input fifo instead
  dsc_sync #(.W(SW)) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_d       (pins_raw),
    .o_q       (pins_s)
  );

  assign {s_a_word, s_b_word, s_flag, s_gate, s_sync, s_rst_n, s_sleep, s_lock} = pins_s;

  // whole-block reset; the synchroniser starts low so the block stays in
  // reset until the pin has been seen high
  logic rst;
  assign rst = i_sys_rst | ~s_rst_n;

  // ==========================================================
  // helpers
  function automatic logic [WW-1:0] order_fix(input logic [WW-1:0] w, input logic rev);
    logic [WW-1:0] r;
    r = w;
    if (rev) begin
      for (int i = 0; i < WW; i++) begin
        r[i] = w[WW-1-i];
      end
    end
    return r;
  endfunction : order_fix

  function automatic dsc_chan_t load_chan(input logic [WW-1:0] code);
    dsc_chan_t c;
    c.valid     = 1'b1;
    c.code_true = code;
    c.code_comp = ~code;
    return c;
  endfunction : load_chan

  // value a channel shows in reset and while the gate is closed: zero code, complement full
  function automatic dsc_chan_t idle_chan();
    dsc_chan_t c;
    c.valid     = 1'b0;
    c.code_true = '0;
    c.code_comp = '1;
    return c;
  endfunction : idle_chan

  // ==========================================================
  // apb register file
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;
  logic [31:0] stat_w;
  dsc_cfg_t    cfg;
  logic        gate;
  dsc_phase_t  phase_r;
  logic        word_taken;

  assign cfg.ilv       = ctrl_r[`DSC_C_ILV];
  assign cfg.bflag_sel = ctrl_r[`DSC_C_BFLAG];
  assign cfg.bit_rev   = ctrl_r[`DSC_C_BITREV];
  assign cfg.pll_mode  = ctrl_r[`DSC_C_PLL];
  assign cfg.lock_clk  = ctrl_r[`DSC_C_LOCKCLK];
  assign cfg.sync_mask = ctrl_r[`DSC_C_SYNC_HI:`DSC_C_SYNC_LO];

  always_comb begin
    stat_w                  = '0;
    stat_w[`DSC_S_GATE]     = gate;
    stat_w[`DSC_S_LOCK]     = s_lock;
    stat_w[`DSC_S_PDN]      = o_power_down;
    stat_w[`DSC_S_NEXTB]    = (phase_r == DSC_PH_B);
    stat_w[`DSC_S_LOCKOUT]  = o_loop_lock_out;
  end

  always_comb begin
    ctrl_nxt    = ctrl_r;
    cnt_nxt     = word_taken ? cnt_r + 32'h00000001 : cnt_r;
    prdata_nxt  = o_prdata;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    // one wait state: pready rises in the second access cycle
    if (i_psel && i_penable && !o_pready) begin
      pready_nxt = 1'b1;
      unique case (i_paddr)
        `DSC_CTRL_OFS: prdata_nxt = ctrl_r;
        `DSC_STAT_OFS: prdata_nxt = stat_w;
        `DSC_CNT_OFS:  prdata_nxt = cnt_r;
        default: begin
          prdata_nxt  = '0;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
    // only the implemented control bits are kept; the rest read back as zero
    if (i_psel && i_penable && o_pready && i_pwrite) begin
      unique case (i_paddr)
        `DSC_CTRL_OFS: ctrl_nxt = {23'h000000, i_pwdata[`DSC_C_SYNC_HI:0]};
        `DSC_CNT_OFS:  cnt_nxt  = '0;
        default:       ctrl_nxt = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      ctrl_r    <= `DSC_CTRL_RST;
      cnt_r     <= '0;
      o_prdata  <= '0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      cnt_r     <= cnt_nxt;
      o_prdata  <= prdata_nxt;
      o_pready  <= pready_nxt;
      o_pslverr <= pslverr_nxt;
    end
  end

  // ==========================================================
  // sample steering
  logic       gate_d_r;
  logic       gate_rise;
  dsc_phase_t phase_cur;
  dsc_phase_t phase_nxt;
  dsc_chan_t  chan_a_nxt;
  dsc_chan_t  chan_b_nxt;
  logic       pdn_nxt;
  logic [WW-1:0] a_fix;
  logic [WW-1:0] b_fix;
  logic       is_b;

  // sleep is treated like a closed gate: nothing reaches the datapath
  assign gate      = s_gate & ~s_sleep;
  assign gate_rise = gate & ~gate_d_r;
  assign a_fix     = order_fix(s_a_word, cfg.bit_rev);
  assign b_fix     = order_fix(s_b_word, cfg.bit_rev);
  assign phase_cur = gate_rise ? DSC_PH_A : phase_r;
  assign word_taken = gate;

  always_comb begin
    chan_a_nxt       = o_chan_a;
    chan_b_nxt       = o_chan_b;
    chan_a_nxt.valid = 1'b0;
    chan_b_nxt.valid = 1'b0;
    phase_nxt        = phase_cur;
    is_b             = 1'b0;
    pdn_nxt          = s_sleep;
    if (!gate) begin
      // datapath held at zero, bus contents dropped
      chan_a_nxt = idle_chan();
      chan_b_nxt = idle_chan();
      phase_nxt  = DSC_PH_A;
    end else if (cfg.ilv) begin
      // the single port carries both channels on chan_a_word
      is_b = cfg.bflag_sel ? s_flag : (phase_cur == DSC_PH_B);
      if (is_b) begin
        chan_b_nxt = load_chan(a_fix);
      end else begin
        chan_a_nxt = load_chan(a_fix);
      end
      unique case (phase_cur)
        DSC_PH_A: phase_nxt = DSC_PH_B;
        DSC_PH_B: phase_nxt = DSC_PH_A;
      endcase
    end else begin
      chan_a_nxt = load_chan(a_fix);
      chan_b_nxt = load_chan(b_fix);
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      gate_d_r     <= 1'b0;
      phase_r      <= DSC_PH_A;
      o_chan_a     <= idle_chan();
      o_chan_b     <= idle_chan();
      o_power_down <= 1'b0;
    end else begin
      gate_d_r     <= gate;
      phase_r      <= phase_nxt;
      o_chan_a     <= chan_a_nxt;
      o_chan_b     <= chan_b_nxt;
      o_power_down <= pdn_nxt;
    end
  end

  // ==========================================================
  // sync event, clock divider and lock pin
  logic             sync_d_r;
  logic             sync_rise;
  dsc_init_t        init_nxt;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic             rate_tgl_r;
  logic             rate_tgl_nxt;
  logic             lock_nxt;

  assign sync_rise = s_sync & ~sync_d_r;

  always_comb begin
    // mask bit order: 0 nco, 1 mixer, 2 divider, 3 fifo
    init_nxt.nco   = sync_rise & cfg.sync_mask[0];
    init_nxt.mixer = sync_rise & cfg.sync_mask[1];
    init_nxt.div   = sync_rise & cfg.sync_mask[2];
    init_nxt.fifo  = sync_rise & cfg.sync_mask[3];
    div_nxt        = init_nxt.div ? '0 : div_r + {{(DIV_W-1){1'b0}}, 1'b1};
    rate_tgl_nxt   = word_taken ? ~rate_tgl_r : rate_tgl_r;
    if (cfg.pll_mode) begin
      lock_nxt = cfg.lock_clk ? div_r[DIV_W-1] : s_lock;
    end else begin
      lock_nxt = rate_tgl_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      sync_d_r        <= 1'b0;
      o_init          <= '0;
      div_r           <= '0;
      rate_tgl_r      <= 1'b0;
      o_loop_lock_out <= 1'b0;
    end else begin
      sync_d_r        <= s_sync;
      o_init          <= init_nxt;
      div_r           <= div_nxt;
      rate_tgl_r      <= rate_tgl_nxt;
      o_loop_lock_out <= lock_nxt;
    end
  end

endmodule : dsc_steer
`default_nettype wire

// ===== verif/dsc_steer_sva.sv
// dsc_steer_sva: port timing checks of the steering block.
// assumes chip_reset_n is held high whenever these are meant to hold.
`timescale 1ns/1ps
`default_nettype none
module dsc_steer_sva
  import dsc_pkg::*;
#(
  parameter int DIV_W = 2
) (
  input wire logic      i_clk,
  input wire logic      i_sys_rst,
  input wire logic      i_psel,
  input wire logic      i_penable,
  input wire logic      i_tx_gate,
  input wire logic      i_sleep,
  input wire logic      i_phase_sync_in,
  input wire logic      o_pready,
  input wire logic      o_pslverr,
  input wire logic      o_power_down,
  input wire dsc_chan_t o_chan_a,
  input wire dsc_chan_t o_chan_b,
  input wire dsc_init_t o_init
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ======
  // data path: pin to output is two sync flops plus one register
  a_gate_zeroes: assert property (
    !i_tx_gate [*3] |=> !o_chan_a.valid && !o_chan_b.valid && o_chan_a.code_true == 16'h0)
    else $error("channel live while gate low");
  a_valid_cause: assert property (
    o_chan_a.valid || o_chan_b.valid |-> $past(i_tx_gate, 3) && !$past(i_sleep, 3))
    else $error("word delivered without gate");
  a_comp_inverse: assert property (
    o_chan_a.code_comp == ~o_chan_a.code_true && o_chan_b.code_comp == ~o_chan_b.code_true)
    else $error("complement code wrong");
  a_init_single: assert property (
    o_init != 4'h0 |=> o_init == 4'h0)
    else $error("init pulse too long");
  a_init_cause: assert property (
    o_init != 4'h0 |-> $past(i_phase_sync_in, 3) && !$past(i_phase_sync_in, 4))
    else $error("init without sync edge");
  a_sleep_down: assert property (
    i_sleep [*3] |=> o_power_down)
    else $error("no power down");
  a_wake_up: assert property (
    !i_sleep [*3] |=> !o_power_down)
    else $error("power down without sleep");
  // ======
  // register bus
  a_one_wait: assert property (
    $rose(i_penable) && i_psel |-> !o_pready ##1 o_pready)
    else $error("ready not after one wait");
  a_ready_pulse: assert property (
    o_pready |=> !o_pready)
    else $error("ready longer than a cycle");
  a_err_ready: assert property (
    o_pslverr |-> o_pready)
    else $error("error without ready");
endmodule : dsc_steer_sva
bind dsc_steer dsc_steer_sva #(.DIV_W(DIV_W)) u_sva (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_tx_gate(i_tx_gate), .i_sleep(i_sleep), .i_phase_sync_in(i_phase_sync_in),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_power_down(o_power_down),
  .o_chan_a(o_chan_a), .o_chan_b(o_chan_b), .o_init(o_init));
`default_nettype wire

// ===== verif/dsc_src_model.sv
// dsc_src_model: sample source on the far side of the data pins.
// assumes i_run is changed by the bench just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module dsc_src_model (
  input  wire logic        i_clk,
  input  wire logic        i_run,
  output var  logic        o_tx_gate,
  output var  logic [15:0] o_a,
  output var  logic [15:0] o_b,
  output var  logic        o_flag
);
  logic [15:0] n = 16'h8001;
  initial begin
    {o_tx_gate, o_a, o_b, o_flag} = 34'h0;
  end
  // words keep changing with the gate low, so ignoring them is really tested
  always @(posedge i_clk) begin
    n         <= n + 16'h1357;
    o_tx_gate <= i_run;
    o_a       <= n;
    o_b       <= ~n ^ 16'h00ff;
    o_flag    <= n[0] ^ n[3];
  end
endmodule : dsc_src_model
`default_nettype wire

// ===== verif/dsc_steer_tb_top.sv
// dsc_steer_tb_top: register and sample-stream checks of the steering block.
// assumes dsc_src_model as data source and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module dsc_steer_tb_top
  import dsc_pkg::*;
;
  logic        i_clk = 1'b0, i_sys_rst = 1'b1, sel = 1'b0, en = 1'b0, wr = 1'b0;
  logic        rn = 1'b0, sync = 1'b0, crst_n = 1'b1, slp = 1'b0, lck = 1'b0;
  logic        gate, fl, rdy, err, pd, lo, lk, isb, ph = 1'b0, mon = 1'b0;
  logic [7:0]  addr = 8'h0;
  logic [15:0] wa, wb, w;
  logic [31:0] wdat = 32'h0, rdat;
  logic [47:0] ha = 48'h0, hb = 48'h0;
  logic [2:0]  hg = 3'h0, hf = 3'h0, cf = 3'h0;
  logic [31:0] modes [5] = '{32'h1e0, 32'h1e1, 32'h1e3, 32'h1e4, 32'h1e7};
  dsc_chan_t   oa, ob;
  dsc_init_t   oi;
  int          miscompares = 0, compares = 0;

  always #5 i_clk = ~i_clk;

  dsc_steer dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(sel), .i_penable(en),
    .i_pwrite(wr), .i_paddr(addr), .i_pwdata(wdat), .o_prdata(rdat), .o_pready(rdy),
    .o_pslverr(err), .i_tx_gate(gate), .i_chan_a_word(wa), .i_chan_b_word(wb),
    .i_b_sample_flag(fl), .i_phase_sync_in(sync), .i_chip_reset_n(crst_n), .i_sleep(slp),
    .i_pll_locked(lck), .o_chan_a(oa), .o_chan_b(ob), .o_init(oi), .o_power_down(pd),
    .o_loop_lock_out(lo));
  dsc_src_model src (.i_clk(i_clk), .i_run(rn), .o_tx_gate(gate), .o_a(wa), .o_b(wb),
    .o_flag(fl));

  // ======
  // helpers
  task automatic conclude();
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask : check

  function automatic logic [15:0] rev(input logic [15:0] v, input logic on);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) r[i] = v[15-i];
    return on ? r : v;
  endfunction : rev

  task automatic apb(input logic w1, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic ee);
    int n;
    @(posedge i_clk);
    {sel, wr, addr, wdat} <= {1'b1, w1, a, d};
    @(posedge i_clk);
    en <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin
      miscompares++;
      conclude();
    end else begin
      if (!w1) check(rdat, e);
      check(32'(err), 32'(ee));
      {sel, en} <= 2'b00;
    end
  endtask : apb

  task automatic pulse(input logic [3:0] e);
    int n;
    @(posedge i_clk);
    sync <= 1'b1;
    n = 0;
    while (oi === 4'h0 && n < 12) begin
      @(posedge i_clk);
      n++;
    end
    check(32'(oi), 32'(e));
    sync <= 1'b0;
  endtask : pulse

  // ======
  // stream monitor: pin history lines up with the three-edge output delay
  always @(posedge i_clk) begin
    {ha, hb} <= {ha[31:0], wa, hb[31:0], wb};
    {hg, hf} <= {hg[1:0], gate, hf[1:0], fl};
  end
  always @(negedge i_clk) if (mon) begin
    w = rev(ha[47:32], cf[2]);
    if (!hg[2]) begin
      check({oa.code_true, ob.code_true}, 32'h0);
      ph = 1'b0;
    end else if (!cf[0]) begin
      check(32'({oa.valid, oa.code_true}), 32'({1'b1, w}));
      check(32'({ob.valid, ob.code_true}), 32'({1'b1, rev(hb[47:32], cf[2])}));
    end else begin
      isb = cf[1] ? hf[2] : ph;
      check(32'({oa.valid, ob.valid, isb ? ob.code_true : oa.code_true}), 32'({~isb, isb, w}));
      ph = ~ph;
    end
  end

  // ======
  // main sequence
  initial begin
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    apb(1'b0, 8'h00, 32'h0, 32'h1e0, 1'b0);
    apb(1'b1, 8'h0c, 32'h5, 32'h0, 1'b1);
    apb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
    mon = 1'b1;
    foreach (modes[k]) begin
      apb(1'b1, 8'h00, modes[k], 32'h0, 1'b0);
      cf = modes[k][2:0];
      repeat (4) @(posedge i_clk);
      rn <= 1'b1;
      repeat (9) @(posedge i_clk);
      rn <= 1'b0;
      repeat (4) @(posedge i_clk);
      rn <= 1'b1;
      repeat (6) @(posedge i_clk);
      rn <= 1'b0;
      repeat (6) @(posedge i_clk);
    end
    apb(1'b0, 8'h08, 32'h0, 32'h4b, 1'b0);
    apb(1'b1, 8'h08, 32'h7, 32'h0, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'h0, 1'b0);
    pulse(4'hf);
    apb(1'b1, 8'h00, 32'h0a0, 32'h0, 1'b0);
    cf = 3'h0;
    pulse(4'ha);
    slp <= 1'b1;
    repeat (5) @(posedge i_clk);
    check(32'(pd), 32'h1);
    slp <= 1'b0;
    apb(1'b1, 8'h00, 32'h1e8, 32'h0, 1'b0);
    lck <= 1'b1;
    repeat (5) @(posedge i_clk);
    check(32'(lo), 32'h1);
    apb(1'b0, 8'h04, 32'h0, 32'h12, 1'b0);
    lck <= 1'b0;
    repeat (5) @(posedge i_clk);
    check(32'(lo), 32'h0);
    apb(1'b1, 8'h00, 32'h1f8, 32'h0, 1'b0);
    repeat (3) @(posedge i_clk);
    lk = lo;
    repeat (2) @(posedge i_clk);
    check(32'(lo ^ lk), 32'h1);
    repeat (2) @(posedge i_clk);
    check(32'(lo ^ lk), 32'h0);
    crst_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    crst_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    apb(1'b0, 8'h00, 32'h0, 32'h1e0, 1'b0);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    conclude();
  end
endmodule : dsc_steer_tb_top
`default_nettype wire
